/* hdl/oag_pkg.sv */
// operand address generator: shared constants, enums and carriers
// assumes a single 200 MHz clock and a classic wishbone master
package oag_pkg;

    // ------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OAG_ADDR_CMD = 8'h00; // write: request
    localparam logic [7:0] OAG_ADDR_DISP = 8'h04; // displacement
    localparam logic [7:0] OAG_ADDR_IMM = 8'h08; // immediate value
    localparam logic [7:0] OAG_ADDR_BASEREG = 8'h0C; // base/ptr regs
    localparam logic [7:0] OAG_ADDR_IDXREG = 8'h10; // index regs
    localparam logic [7:0] OAG_ADDR_SEGREG = 8'h14; // code/stack segs
    localparam logic [7:0] OAG_ADDR_SEGREG2 = 8'h18; // data/extra segs
    localparam logic [7:0] OAG_ADDR_GPREG = 8'h1C; // accum/count regs
    localparam logic [7:0] OAG_ADDR_RESULT = 8'h20; // seg:offset
    localparam logic [7:0] OAG_ADDR_STATUS = 8'h24; // flags, state
    localparam logic [7:0] OAG_ADDR_EXT = 8'h28; // ext ready, irq

    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int OAG_CMD_MODE_LSB = 0;   // 3-bit addressing mode
    localparam int OAG_CMD_BASE_SEL = 3;   // 0 general base, 1 ptr
    localparam int OAG_CMD_IDX_SEL = 4;    // 0 source, 1 dest index
    localparam int OAG_CMD_DISP16 = 5;     // displacement is 16 bits
    localparam int OAG_CMD_REF_LSB = 6;    // 2-bit reference kind
    localparam int OAG_CMD_OVR_EN = 8;     // override prefix present
    localparam int OAG_CMD_OVR_LSB = 9;    // 2-bit override segment
    localparam int OAG_CMD_WIDE = 11;      // register operand 16 bit
    localparam int OAG_CMD_REG_LSB = 12;   // 3-bit register number
    localparam int OAG_CMD_OP_LSB = 16;    // 4-bit control op
    localparam int OAG_CMD_LOCK = 20;      // lock prefix

    localparam logic [15:0] OAG_SEG_RST = 16'h0000;
    localparam logic [31:0] OAG_BUS_ZERO = 32'h0000_0000;

    // segment register choice
    typedef enum logic [1:0] {
        OAG_SEG_EXTRA = 2'b00,
        OAG_SEG_CODE = 2'b01,
        OAG_SEG_STACK = 2'b10,
        OAG_SEG_DATA = 2'b11
    } oag_seg_t;

    // operand addressing modes
    typedef enum logic [2:0] {
        OAG_MODE_REG = 3'b000,
        OAG_MODE_IMM = 3'b001,
        OAG_MODE_DIRECT = 3'b010,
        OAG_MODE_INDIRECT = 3'b011,
        OAG_MODE_BASED = 3'b100,
        OAG_MODE_INDEXED = 3'b101,
        OAG_MODE_BASE_IDX = 3'b110,
        OAG_MODE_BASE_IDX_DISP = 3'b111
    } oag_mode_t;

    // kind of memory reference
    typedef enum logic [1:0] {
        OAG_REF_DATA = 2'b00,
        OAG_REF_FETCH = 2'b01,
        OAG_REF_STACK = 2'b10,
        OAG_REF_STRDST = 2'b11
    } oag_ref_t;

    // processor control operations
    typedef enum logic [3:0] {
        OAG_OP_NONE = 4'h0,
        OAG_OP_CARRY_SET = 4'h1,
        OAG_OP_CARRY_CLR = 4'h2,
        OAG_OP_CARRY_INV = 4'h3,
        OAG_OP_DIR_SET = 4'h4,
        OAG_OP_DIR_CLR = 4'h5,
        OAG_OP_IRQ_SET = 4'h6,
        OAG_OP_IRQ_CLR = 4'h7,
        OAG_OP_HALT = 4'h8,
        OAG_OP_SYNC = 4'h9,
        OAG_OP_CZ_JUMP = 4'hA,
        OAG_OP_END_INSN = 4'hB
    } oag_op_t;

    // execution state
    typedef enum logic [1:0] {
        OAG_ST_RUN = 2'b00,
        OAG_ST_HALT = 2'b01,
        OAG_ST_SYNC = 2'b10
    } oag_state_t;

    // computed operand address
    typedef struct packed {
        logic [15:0] selector;
        logic [15:0] offset;
    } oag_addr_t;

endpackage

/* hdl/oag_top.sv */
// operand address generator with processor control state
// assumes a classic wishbone master and an async extension input
// writes land at the edge that raises ack; reads return with ack
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
module oag_top
    import oag_pkg::*;
(
    input wire logic clk_i,               // 200 MHz clock
    input wire logic rst_i,               // sync reset, active high
    input wire logic wb_cyc_i,            // wishbone cycle
    input wire logic wb_stb_i,            // wishbone strobe
    input wire logic wb_we_i,             // write enable
    input wire logic [7:0] wb_adr_i,      // byte address
    input wire logic [3:0] wb_sel_i,      // byte lanes
    input wire logic [31:0] wb_dat_i,     // write data
    output logic [31:0] wb_dat_o,         // read data
    output logic wb_ack_o,                // acknowledge
    input wire logic ext_ready_i,         // extension ready pin
    input wire logic irq_i,               // interrupt taken pin
    output logic [31:0] addr_o,           // selector and offset
    output logic [15:0] operand_o,        // register/immediate operand
    output logic addr_valid_o,            // one-cycle result strobe
    output logic bus_lock_o,              // bus locked
    output logic halted_o,                // execution stopped
    output logic jump_taken_o             // count-zero jump result
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] disp;            // displacement from instruction
    logic [15:0] imm;             // immediate operand
    // base, pointer and index registers, loaded over the bus
    logic [15:0] general_base_reg;
    logic [15:0] base_pointer_reg;
    logic [15:0] src_index_reg;
    logic [15:0] dest_index_reg;
    // segment registers that supply the selector
    logic [15:0] code_segment_reg;
    logic [15:0] stack_segment_reg;
    logic [15:0] data_segment_reg;
    logic [15:0] extra_segment_reg;
    logic [15:0] accum_reg;
    logic [15:0] loop_count_reg;
    // flags changed only by the dedicated flag ops
    logic carry_flag;
    logic direction_flag;
    logic irq_enable_flag;
    oag_state_t state;
    logic [2:0] ext_sync;         // three-stage pin synchroniser
    logic [2:0] irq_sync;
    logic ext_seen;               // level on which stages two and three last agreed
    logic irq_seen;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic bus_req;
    logic wr_stb;
    logic [31:0] cmd;
    oag_mode_t mode;
    oag_ref_t ref_kind;
    oag_op_t op;

    // ack blocks the edge after taking, so one request acts once
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = bus_req && wb_we_i;
    // command fields decode straight from the write data
    assign cmd = wb_dat_i;
    assign mode = oag_mode_t'(cmd[OAG_CMD_MODE_LSB +: 3]);
    assign ref_kind = oag_ref_t'(cmd[OAG_CMD_REF_LSB +: 2]);
    assign op = oag_op_t'(cmd[OAG_CMD_OP_LSB +: 4]);

    // merge byte lanes into a 16-bit field
    function automatic logic [15:0] lane16(input logic [15:0] old,
        input logic [15:0] nw, input logic [1:0] sel);
        lane16 = {sel[1] ? nw[15:8] : old[15:8],
                  sel[0] ? nw[7:0] : old[7:0]};
    endfunction

    // segment register value for a choice
    function automatic logic [15:0] seg_val(input oag_seg_t s,
        input logic [15:0] cs, input logic [15:0] ss,
        input logic [15:0] ds, input logic [15:0] es);
        case (s)
            OAG_SEG_CODE: seg_val = cs;
            OAG_SEG_STACK: seg_val = ss;
            OAG_SEG_DATA: seg_val = ds;
            default: seg_val = es;
        endcase
    endfunction

    // ------------------------------------------------------------
    // offset and segment computation
    // ------------------------------------------------------------
    logic [15:0] disp_ext;
    logic [15:0] base_val;
    logic [15:0] idx_val;
    logic [15:0] next_offset;
    oag_seg_t next_seg;
    logic [15:0] next_operand;
    logic [15:0] reg_word;

    // offset, segment and operand of the command now on the bus
    // settle here and are captured only when the command is taken
    always_comb begin
        disp_ext = cmd[OAG_CMD_DISP16] ? disp : {{8{disp[7]}}, disp[7:0]};
        base_val = cmd[OAG_CMD_BASE_SEL] ? base_pointer_reg
                                         : general_base_reg;
        idx_val = cmd[OAG_CMD_IDX_SEL] ? dest_index_reg : src_index_reg;
        case (mode)
            OAG_MODE_DIRECT: next_offset = disp_ext;
            OAG_MODE_INDIRECT: begin
                case (cmd[OAG_CMD_IDX_SEL +: 2])
                    2'b00: next_offset = src_index_reg;
                    2'b01: next_offset = dest_index_reg;
                    default: next_offset = base_val;
                endcase
            end
            OAG_MODE_BASED: next_offset = 16'(base_val + disp_ext);
            OAG_MODE_INDEXED: next_offset = 16'(idx_val + disp_ext);
            OAG_MODE_BASE_IDX: next_offset = 16'(base_val + idx_val);
            OAG_MODE_BASE_IDX_DISP:
                next_offset = 16'(base_val + idx_val + disp_ext);
            default: next_offset = 16'h0000;
        endcase
        // implicit segment choice
        case (ref_kind)
            OAG_REF_FETCH: next_seg = OAG_SEG_CODE;
            OAG_REF_STACK: next_seg = OAG_SEG_STACK;
            OAG_REF_STRDST: next_seg = OAG_SEG_EXTRA;
            default: next_seg = OAG_SEG_DATA;
        endcase
        // in indirect mode bit five picks a base register and bit
        // three the pointer, so only that pair means a pointer base
        // base pointer as base element
        if (ref_kind == OAG_REF_DATA && cmd[OAG_CMD_BASE_SEL] &&
            (mode == OAG_MODE_BASED || mode == OAG_MODE_BASE_IDX ||
             mode == OAG_MODE_BASE_IDX_DISP ||
             (mode == OAG_MODE_INDIRECT && cmd[OAG_CMD_DISP16]))) begin
            next_seg = OAG_SEG_STACK;
        end
        // override prefix wins, never for prefetch
        if (cmd[OAG_CMD_OVR_EN] && ref_kind != OAG_REF_FETCH) begin
            next_seg = oag_seg_t'(cmd[OAG_CMD_OVR_LSB +: 2]);
        end
        case (cmd[OAG_CMD_REG_LSB +: 3])
            3'd0: reg_word = accum_reg;
            3'd1: reg_word = loop_count_reg;
            3'd2: reg_word = general_base_reg;
            3'd3: reg_word = base_pointer_reg;
            3'd4: reg_word = src_index_reg;
            default: reg_word = dest_index_reg;
        endcase
        if (mode == OAG_MODE_IMM) begin
            next_operand = imm;
        end else if (cmd[OAG_CMD_WIDE]) begin
            next_operand = reg_word;
        end else begin
            next_operand = {8'h00, reg_word[7:0]};
        end
    end

    // commands are refused outside run, but still acked
    logic cmd_wr;
    assign cmd_wr = wr_stb && wb_adr_i == OAG_ADDR_CMD && state == OAG_ST_RUN;

    // ------------------------------------------------------------
    // result outputs
    // ------------------------------------------------------------
    // selector and offset presented together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_o <= OAG_BUS_ZERO;
            operand_o <= 16'h0000;
            addr_valid_o <= 1'b0;
        end else begin
            addr_valid_o <= cmd_wr && op == OAG_OP_NONE &&
                            mode != OAG_MODE_REG && mode != OAG_MODE_IMM;
            if (cmd_wr && op == OAG_OP_NONE) begin
                addr_o <= {seg_val(next_seg, code_segment_reg,
                    stack_segment_reg, data_segment_reg,
                    extra_segment_reg), next_offset};
                operand_o <= next_operand;
            end
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // three flops per pin; a level counts once stages two and three
    // agree, so a one-cycle glitch never wakes the machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync <= 3'b000;
            irq_sync <= 3'b000;
            ext_seen <= 1'b0;
            irq_seen <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_ready_i};
            irq_sync <= {irq_sync[1:0], irq_i};
            if (ext_sync[1] == ext_sync[2]) ext_seen <= ext_sync[2];
            if (irq_sync[1] == irq_sync[2]) irq_seen <= irq_sync[2];
        end
    end

    // ------------------------------------------------------------
    // execution state machine
    // ------------------------------------------------------------
    // only the run state accepts commands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= OAG_ST_RUN;
        end else begin
            case (state)
                OAG_ST_RUN: begin
                    if (cmd_wr && op == OAG_OP_HALT) state <= OAG_ST_HALT;
                    else if (cmd_wr && op == OAG_OP_SYNC && !ext_seen)
                        state <= OAG_ST_SYNC;
                end
                OAG_ST_HALT: if (irq_seen) state <= OAG_ST_RUN;
                OAG_ST_SYNC: if (ext_seen) state <= OAG_ST_RUN;
                default: state <= OAG_ST_RUN;
            endcase
        end
    end

    // halted is high in both halt and sync wait
    always_ff @(posedge clk_i) begin
        if (rst_i) halted_o <= 1'b0;
        else halted_o <= state != OAG_ST_RUN;
    end

    // ------------------------------------------------------------
    // flags, lock and count-zero jump
    // ------------------------------------------------------------
    // flag, lock and jump ops act only on an accepted command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry_flag <= 1'b0;
            direction_flag <= 1'b0;
            irq_enable_flag <= 1'b0;
            bus_lock_o <= 1'b0;
            jump_taken_o <= 1'b0;
        end else if (cmd_wr) begin
            case (op)
                OAG_OP_CARRY_SET: carry_flag <= 1'b1;
                OAG_OP_CARRY_CLR: carry_flag <= 1'b0;
                OAG_OP_CARRY_INV: carry_flag <= !carry_flag;
                OAG_OP_DIR_SET: direction_flag <= 1'b1;
                OAG_OP_DIR_CLR: direction_flag <= 1'b0;
                OAG_OP_IRQ_SET: irq_enable_flag <= 1'b1;
                OAG_OP_IRQ_CLR: irq_enable_flag <= 1'b0;
                OAG_OP_CZ_JUMP: jump_taken_o <= loop_count_reg == 16'h0000;
                default: ;
            endcase
            if (cmd[OAG_CMD_LOCK]) bus_lock_o <= 1'b1;
            else if (op == OAG_OP_END_INSN) bus_lock_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register file writes
    // ------------------------------------------------------------
    // paired registers: low half on lanes 0-1, high half on 2-3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp <= 16'h0000;
            imm <= 16'h0000;
            general_base_reg <= 16'h0000;
            base_pointer_reg <= 16'h0000;
            src_index_reg <= 16'h0000;
            dest_index_reg <= 16'h0000;
            code_segment_reg <= OAG_SEG_RST;
            stack_segment_reg <= OAG_SEG_RST;
            data_segment_reg <= OAG_SEG_RST;
            extra_segment_reg <= OAG_SEG_RST;
            accum_reg <= 16'h0000;
            loop_count_reg <= 16'h0000;
        end else if (wr_stb) begin
            case (wb_adr_i)
                OAG_ADDR_DISP:
                    disp <= lane16(disp, wb_dat_i[15:0], wb_sel_i[1:0]);
                OAG_ADDR_IMM:
                    imm <= lane16(imm, wb_dat_i[15:0], wb_sel_i[1:0]);
                OAG_ADDR_BASEREG: begin
                    general_base_reg <= lane16(general_base_reg,
                        wb_dat_i[15:0], wb_sel_i[1:0]);
                    base_pointer_reg <= lane16(base_pointer_reg,
                        wb_dat_i[31:16], wb_sel_i[3:2]);
                end
                OAG_ADDR_IDXREG: begin
                    src_index_reg <= lane16(src_index_reg,
                        wb_dat_i[15:0], wb_sel_i[1:0]);
                    dest_index_reg <= lane16(dest_index_reg,
                        wb_dat_i[31:16], wb_sel_i[3:2]);
                end
                OAG_ADDR_SEGREG: begin
                    code_segment_reg <= lane16(code_segment_reg,
                        wb_dat_i[15:0], wb_sel_i[1:0]);
                    stack_segment_reg <= lane16(stack_segment_reg,
                        wb_dat_i[31:16], wb_sel_i[3:2]);
                end
                OAG_ADDR_SEGREG2: begin
                    data_segment_reg <= lane16(data_segment_reg,
                        wb_dat_i[15:0], wb_sel_i[1:0]);
                    extra_segment_reg <= lane16(extra_segment_reg,
                        wb_dat_i[31:16], wb_sel_i[3:2]);
                end
                OAG_ADDR_GPREG: begin
                    accum_reg <= lane16(accum_reg,
                        wb_dat_i[15:0], wb_sel_i[1:0]);
                    loop_count_reg <= lane16(loop_count_reg,
                        wb_dat_i[31:16], wb_sel_i[3:2]);
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus answer: ack one cycle after request, reads registered
    // ------------------------------------------------------------
    // read data follows the address of the request being acked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= OAG_BUS_ZERO;
        end else begin
            wb_ack_o <= bus_req;
            case (wb_adr_i)
                OAG_ADDR_DISP: wb_dat_o <= {16'h0000, disp};
                OAG_ADDR_IMM: wb_dat_o <= {16'h0000, imm};
                OAG_ADDR_BASEREG:
                    wb_dat_o <= {base_pointer_reg, general_base_reg};
                OAG_ADDR_IDXREG:
                    wb_dat_o <= {dest_index_reg, src_index_reg};
                OAG_ADDR_SEGREG:
                    wb_dat_o <= {stack_segment_reg, code_segment_reg};
                OAG_ADDR_SEGREG2:
                    wb_dat_o <= {extra_segment_reg, data_segment_reg};
                OAG_ADDR_GPREG: wb_dat_o <= {loop_count_reg, accum_reg};
                OAG_ADDR_RESULT: wb_dat_o <= addr_o;
                OAG_ADDR_STATUS:
                    wb_dat_o <= {24'h000000, jump_taken_o, bus_lock_o,
                                 state, 1'b0, irq_enable_flag,
                                 direction_flag, carry_flag};
                OAG_ADDR_EXT:
                    wb_dat_o <= {30'h00000000, irq_seen, ext_seen};
                default: wb_dat_o <= OAG_BUS_ZERO;
            endcase
        end
    end

endmodule

/* dv/oag_ext_model.sv */
// far-side model: interrupt source and extension unit
// assumes the bench raises a request level per wake event
`timescale 1ns/1ps
module oag_ext_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_req_i,
    input wire logic ext_req_i,
    input wire logic [3:0] dly_i,
    output logic irq_o,
    output logic ext_ready_o
);
    logic [3:0] cnt; // cycles since request
    // answer after dly_i cycles, held while asked
    always_ff @(posedge clk_i) begin
        if (rst_i || !(irq_req_i || ext_req_i)) begin
            cnt <= 4'h0;
        end else if (cnt < dly_i) begin
            cnt <= cnt + 4'h1;
        end
    end
    assign irq_o = irq_req_i && cnt == dly_i;
    assign ext_ready_o = ext_req_i && cnt == dly_i;
endmodule

/* dv/oag_monitor.sv */
// port checker for the operand address generator
// assumes it is bound to oag_top
`timescale 1ns/1ps
module oag_monitor
    import oag_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic ext_ready_i,
    input wire logic irq_i,
    input wire logic addr_valid_o,
    input wire logic bus_lock_o,
    input wire logic halted_o,
    input wire logic jump_taken_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic req = wb_cyc_i && wb_stb_i; // open request
    a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |->
        $past(req) ##1 !wb_ack_o) else $error("ack not a pulse");
    a_valid_cmd: assert property (addr_valid_o |-> wb_ack_o &&
        $past(wb_we_i && wb_adr_i == OAG_ADDR_CMD))
        else $error("stray valid");
    a_valid_pulse: assert property (addr_valid_o |=> !addr_valid_o)
        else $error("valid too long");
    // halted one edge after the taking edge shows the state it was taken in
    a_halt_refuse: assert property (req && !wb_ack_o ##1 halted_o
        |-> !addr_valid_o) else $error("command taken while halted");
    a_wake_cause: assert property ($fell(halted_o)
        |-> irq_i || ext_ready_i) else $error("wake without cause");
    a_lock_at_ack: assert property ($changed(bus_lock_o)
        |-> wb_ack_o) else $error("lock moved off a command");
    a_jump_at_ack: assert property ($changed(jump_taken_o)
        |-> wb_ack_o) else $error("jump moved off a command");
    a_unmapped_zero: assert property (wb_ack_o &&
        $past(!wb_we_i && wb_adr_i == 8'h2C)
        |-> wb_dat_o == OAG_BUS_ZERO) else $error("bad read");
endmodule
bind oag_top oag_monitor i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ext_ready_i, .irq_i,
    .addr_valid_o, .bus_lock_o, .halted_o, .jump_taken_o);

/* dv/oag_top_tb.sv */
// bench for oag_top: register model, wishbone master, wake source
// assumes the far-side model in oag_ext_model
`timescale 1ns/1ps
module oag_top_tb;
    import oag_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, addr, q, cmd, lfsr = 32'h431F;
    logic ack, ext, irq, valid, lock, halted, jump, irq_req = 0, ext_req = 0;
    logic [15:0] operand, disp, imm, cx;
    logic [15:0] r [10]; // bx bp si di cs ss ds es ax cx
    logic [3:0] dly = 4'h1;
    logic [2:0] fl = 3'h0; // carry, direction, irq enable
    int mismatches = 0, check_count = 0;
    localparam int SMAP [4] = '{7, 4, 5, 6};
    localparam int RMAP [6] = '{8, 9, 0, 1, 2, 3};
    always #2.5 clk_i = ~clk_i;
    oag_top i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_ready_i(ext), .irq_i(irq),
        .addr_o(addr), .operand_o(operand), .addr_valid_o(valid),
        .bus_lock_o(lock), .halted_o(halted), .jump_taken_o(jump));
    oag_ext_model i_ext (.clk_i, .rst_i, .irq_req_i(irq_req),
        .ext_req_i(ext_req), .dly_i(dly), .irq_o(irq), .ext_ready_o(ext));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // expected selector and offset of a memory-mode command
    function automatic logic [31:0] model(input logic [31:0] c);
        logic [15:0] d, b, x, o;
        logic [1:0] s;
        logic bp;
        d = c[5] ? disp : {{8{disp[7]}}, disp[7:0]};
        b = c[3] ? r[1] : r[0];
        x = c[4] ? r[3] : r[2];
        bp = c[3] && (c[2] ? (!c[0] || c[1]) : (c[1] && c[0] && c[5]));
        case (c[2:0])
            3'd2: o = d;
            3'd3: o = c[5] ? b : x;
            3'd4: o = d + b;
            3'd5: o = d + x;
            3'd6: o = b + x;
            default: o = b + x + d;
        endcase
        s = c[7:6] == 2'd1 ? 2'd1 : c[8] ? c[10:9] : c[7:6] == 2'd2 ? 2'd2 :
            c[7:6] == 2'd3 ? 2'd0 : bp ? 2'd2 : 2'd3;
        return {r[SMAP[s]], o};
    endfunction
    task automatic final_report();
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic wishbone cycle, released after ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        repeat (50) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (ack !== 1'b1) begin
            chk(0, 1);
            final_report();
        end
        q = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic wait_halt(input logic v);
        repeat (60) begin
            @(posedge clk_i);
            if (halted === v) break;
        end
        chk(halted, v);
        if (halted !== v) final_report();
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        for (int k = 0; k < 7; k++) begin
            lfsr = nxt(lfsr);
            wb(1, 8'(4 + 4 * k), lfsr);
            if (k == 0) disp = lfsr[15:0];
            if (k == 1) imm = lfsr[15:0];
            if (k > 1) {r[2 * k - 3], r[2 * k - 4]} = lfsr;
        end
        for (int t = 0; t < 60; t++) begin
            lfsr = nxt(lfsr);
            cmd = (lfsr & 32'h7F8) | 32'(2 + t % 6);
            wb(1, OAG_ADDR_CMD, cmd);
            chk(addr, model(cmd));
            chk(valid, 1);
        end
        for (int n = 0; n < 6; n++) begin
            wb(1, OAG_ADDR_CMD, 32'h800 | 32'(n << 12));
            chk(operand, r[RMAP[n]]);
            chk(valid, 0);
            wb(1, OAG_ADDR_CMD, 32'(n << 12));
            chk(operand, {8'h00, r[RMAP[n]][7:0]});
        end
        wb(1, OAG_ADDR_CMD, 32'h1);
        chk(operand, imm);
        for (int t = 0; t < 14; t++) begin
            wb(1, OAG_ADDR_CMD, 32'((1 + t % 7) << 16));
            case (1 + t % 7)
                1: fl[0] = 1;
                2: fl[0] = 0;
                3: fl[0] = !fl[0];
                4: fl[1] = 1;
                5: fl[1] = 0;
                6: fl[2] = 1;
                default: fl[2] = 0;
            endcase
            wb(0, OAG_ADDR_STATUS, 0);
            chk(q[2:0], fl);
        end
        cmd = addr;
        wb(1, OAG_ADDR_CMD, 32'h80000);
        wb(1, OAG_ADDR_CMD, 32'h2);
        chk(addr, cmd);
        chk(valid, 0);
        wait_halt(1);
        dly <= lfsr[3:0];
        irq_req <= 1;
        wait_halt(0);
        irq_req <= 0;
        wb(1, OAG_ADDR_CMD, 32'h90000);
        wait_halt(1);
        dly <= 4'hF;
        ext_req <= 1;
        wait_halt(0);
        repeat (20) @(posedge clk_i);
        wb(1, OAG_ADDR_CMD, 32'h90000);
        repeat (3) @(posedge clk_i);
        chk(halted, 0);
        ext_req <= 0;
        wb(1, OAG_ADDR_CMD, 32'h100002);
        wb(1, OAG_ADDR_CMD, 32'h2);
        chk(lock, 1);
        wb(1, OAG_ADDR_CMD, 32'hB0000);
        chk(lock, 0);
        for (int k = 0; k < 3; k++) begin
            cx = k == 1 ? 16'h0000 : k == 0 ? 16'h0001 : 16'h8000;
            wb(1, OAG_ADDR_GPREG, {cx, r[8]});
            wb(1, OAG_ADDR_CMD, 32'hA0000);
            chk(jump, cx == 16'h0000);
        end
        wb(0, 8'h2C, 0);
        chk(q, 0);
        final_report();
    end
endmodule
